// ### pkg/sibdec_pkg.sv
// Shared constants, enumerations and carriers for the addressing and operand field decoder.
package sibdec_pkg;

  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [1:0] SIBDEC_MOD_NODISP = 2'h0;      // No displacement.
  localparam logic [1:0] SIBDEC_MOD_BYTE   = 2'h1;      // Byte displacement follows.
  localparam logic [1:0] SIBDEC_MOD_LONG   = 2'h2;      // Long displacement follows.
  localparam logic [1:0] SIBDEC_MOD_REG    = 2'h3;      // Register operand, no memory.
  localparam logic [2:0] SIBDEC_RM_SIB     = 3'h4;      // Register/memory code that calls for a scale-index-base byte.
  localparam logic [2:0] SIBDEC_INDEX_NONE = 3'h4;      // Index code meaning no index register.
  localparam logic [2:0] SIBDEC_BASE_STACK = 3'h4;      // Base code of the stack pointer register.
  localparam logic [2:0] SIBDEC_BASE_FRAME = 3'h5;      // Base code of the frame base register.
  localparam logic [2:0] SIBDEC_DISP_NONE  = 3'h0;      // Displacement length in bytes: none.
  localparam logic [2:0] SIBDEC_DISP_BYTE  = 3'h1;      // Displacement length in bytes: one.
  localparam logic [2:0] SIBDEC_DISP_LONG  = 3'h4;      // Displacement length in bytes: four.
  localparam int         SIBDEC_GPR_COUNT  = 8;         // General registers in the file.
  localparam int         SIBDEC_GPR_WIDTH  = 32;        // Width of one general register.

  // ****************************************
  // Enumerations
  // ****************************************
  // Segment registers, in two- and three-bit selector order; none marks a reserved code.
  typedef enum logic [2:0] {SIBDEC_SEG_EXTRA, SIBDEC_SEG_CODE, SIBDEC_SEG_STACK, SIBDEC_SEG_DATA,
                            SIBDEC_SEG_ADD_ONE, SIBDEC_SEG_ADD_TWO, SIBDEC_SEG_NONE} sibdec_seg_type;
  // Which part of a general register an operand uses.
  typedef enum logic [1:0] {SIBDEC_PART_FULL, SIBDEC_PART_LOW, SIBDEC_PART_HIGH} sibdec_part_type;
  // Where the general-register selector comes from.
  typedef enum logic [1:0] {SIBDEC_SRC_OPCODE, SIBDEC_SRC_REGFIELD, SIBDEC_SRC_RMFIELD} sibdec_regsrc_type;

  // ****************************************
  // Carriers
  // ****************************************
  // One decode request from the fetch logic.
  typedef struct packed {
    logic              addr32;         // Addressing is 32-bit.
    logic [7:0]        modrm;          // First addressing byte.
    logic [7:0]        sib;            // Scale-index-base byte.
    logic [31:0]       disp;           // Displacement bytes as fetched, low byte first.
    logic              opsize32;       // Operation size is 32-bit.
    logic              w_present;      // Operand-length bit exists in the opcode.
    logic              w;              // Operand-length bit.
    logic              d;              // Direction bit.
    sibdec_regsrc_type reg_src;        // Source of the general-register selector.
    logic [2:0]        opcode_reg;     // Register selector carried in the opcode byte.
    logic [1:0]        seg2;           // Two-bit segment selector.
    logic [2:0]        seg3;           // Three-bit segment selector.
    logic              frame16_based;  // Operand addressed through the 16-bit frame base register.
    logic              string_dst;     // Destination of a string primitive.
    logic              override_valid; // Segment override prefix present.
    sibdec_seg_type    override_seg;   // Segment named by the override.
  } sibdec_req_type;

  // One decode result towards address generation and the register file.
  typedef struct packed {
    logic [31:0]       effective_address; // Address formed from the addressing bytes.
    logic              sib_present;       // A scale-index-base byte is expected.
    logic [2:0]        disp_len;          // Displacement bytes that follow the addressing bytes.
    sibdec_seg_type    default_seg;       // Default segment of the address.
    sibdec_seg_type    operand_seg;       // Segment used after override handling.
    sibdec_seg_type    seg2_reg;          // Two-bit selector decoded.
    sibdec_seg_type    seg3_reg;          // Three-bit selector decoded.
    logic              seg3_reserved;     // Three-bit selector held a reserved code.
    logic              gpr_valid;         // A general register operand is named.
    logic [2:0]        gpr_num;           // General register number.
    sibdec_part_type   gpr_part;          // Part of that register.
    logic              gpr_width16;       // A full register is 16-bit wide.
    logic              reg_is_dst;        // Register field names the destination.
  } sibdec_res_type;

endpackage : sibdec_pkg

// ### verilog/sibdec_decoder.sv
// Addressing byte, segment, register and direction field decoder with registered results.
`timescale 1ns/1ps

// Behaviour
// RQ1: Scale byte needs 32-bit addressing, r/m 100, memory.
// RQ2: Scale code gives multiplier one, two, four, eight.
// RQ3: Scaled index is index register times multiplier.
// RQ4: Index code 100 means no index register.
// RQ5: Producers keep scale 00 when index is 100.
// RQ6: Base code selects registers 0 to 7.
// RQ7: Base 101 with mode 00 uses long displacement.
// RQ8: Mode from first byte, base, index from second.
// RQ9: Address adds none, byte or long displacement.
// RQ10: Stack segment for stack or framed base.
// RQ11: Length bit picks byte or full operation size.
// RQ12: Two-bit selector decodes extra, code, stack, data.
// RQ13: Three-bit selector adds two segments, two reserved.
// RQ14: Register selector from opcode, reg or register r/m.
// RQ15: Full registers when length bit absent or one.
// RQ16: Length zero picks low or second bytes.
// RQ17: Sixteen-bit frame base operands use stack segment.
// RQ18: String destinations always use extra segment.
// RQ19: Direction bit picks register as source or destination.
// RQ20: Reserved three-bit selector raises an exception flag.
module sibdec_decoder #(
  parameter int GPR_COUNT = sibdec_pkg::SIBDEC_GPR_COUNT, // Registers in the general file.
  parameter int GPR_WIDTH = sibdec_pkg::SIBDEC_GPR_WIDTH  // Width of one register.
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  req_valid,
  input  wire sibdec_pkg::sibdec_req_type            req,
  input  wire logic [GPR_COUNT-1:0][GPR_WIDTH-1:0]   gpr_values,
  output logic                                       res_valid,
  output sibdec_pkg::sibdec_res_type                 res,
  output logic                                       seg_fault
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Shared segment selector decode; the two-bit form is zero extended, so its codes match.
  function automatic sibdec_pkg::sibdec_seg_type seg_decode(input logic [2:0] code);
    sibdec_pkg::sibdec_seg_type seg;
    unique case (code)
      3'h0:    seg = sibdec_pkg::SIBDEC_SEG_EXTRA;   // RQ12
      3'h1:    seg = sibdec_pkg::SIBDEC_SEG_CODE;    // RQ12
      3'h2:    seg = sibdec_pkg::SIBDEC_SEG_STACK;   // RQ12
      3'h3:    seg = sibdec_pkg::SIBDEC_SEG_DATA;    // RQ12
      3'h4:    seg = sibdec_pkg::SIBDEC_SEG_ADD_ONE; // RQ13
      3'h5:    seg = sibdec_pkg::SIBDEC_SEG_ADD_TWO; // RQ13
      default: seg = sibdec_pkg::SIBDEC_SEG_NONE;    // RQ13
    endcase
    return seg;
  endfunction : seg_decode

  // Scale code to multiplier.
  function automatic logic [3:0] scale_mult(input logic [1:0] ss);
    logic [3:0] m;
    unique case (ss)
      2'h0: m = 4'h1; // RQ2
      2'h1: m = 4'h2; // RQ2
      2'h2: m = 4'h4; // RQ2
      2'h3: m = 4'h8; // RQ2
    endcase
    return m;
  endfunction : scale_mult

  // ****************************************
  // Field extraction
  // ****************************************
  logic [1:0]  mod_f;   // Mode field of the first addressing byte.
  logic [2:0]  rm_f;    // Register/memory field.
  logic [2:0]  regf_f;  // Register field.
  logic [1:0]  ss_f;    // Scale code.
  logic [2:0]  idx_f;   // Index selector.
  logic [2:0]  base_f;  // Base selector.

  // Mode always comes from the first byte, base and index from the second.
  assign mod_f  = req.modrm[7:6]; // RQ8
  assign regf_f = req.modrm[5:3];
  assign rm_f   = req.modrm[2:0];
  assign ss_f   = req.sib[7:6];   // RQ8
  assign idx_f  = req.sib[5:3];   // RQ8
  assign base_f = req.sib[2:0];   // RQ8

  // ****************************************
  // Next result
  // ****************************************
  sibdec_pkg::sibdec_res_type res_next;   // Result to register.
  logic                       valid_next; // Result valid next cycle.
  sibdec_pkg::sibdec_res_type res_reg;    // Registered result.
  logic                       valid_reg;  // Registered valid.

  // Full decode of one request. An index code of 100 with a nonzero scale is left to the
  // producer; the index term is simply zero then, which is one legal undefined value.
  always_comb begin
    logic [31:0] base_term;
    logic [31:0] index_term;
    logic [31:0] disp_term;
    logic [2:0]  sel;
    base_term  = '0;
    index_term = '0;
    disp_term  = '0;
    sel        = req.opcode_reg;
    res_next   = '0;
    valid_next = req_valid;
    // Scale-index-base byte expected only in 32-bit addressing with r/m 100 and memory mode.
    res_next.sib_present = req.addr32 && rm_f == sibdec_pkg::SIBDEC_RM_SIB
                           && mod_f != sibdec_pkg::SIBDEC_MOD_REG; // RQ1
    // Base selector indexes the register file in code order.
    base_term = gpr_values[base_f][31:0]; // RQ6
    // No index register for code 100, otherwise the scaled register value.
    if (idx_f != sibdec_pkg::SIBDEC_INDEX_NONE) begin // RQ4 RQ5
      index_term = 32'(gpr_values[idx_f][31:0] * scale_mult(ss_f)); // RQ3
    end
    // Displacement length follows the mode field.
    unique case (mod_f)
      sibdec_pkg::SIBDEC_MOD_BYTE: begin
        disp_term         = {{24{req.disp[7]}}, req.disp[7:0]}; // RQ9
        res_next.disp_len = sibdec_pkg::SIBDEC_DISP_BYTE;       // RQ9
      end
      sibdec_pkg::SIBDEC_MOD_LONG: begin
        disp_term         = req.disp;                           // RQ9
        res_next.disp_len = sibdec_pkg::SIBDEC_DISP_LONG;       // RQ9
      end
      default: begin
        disp_term         = '0;                                 // RQ9
        res_next.disp_len = sibdec_pkg::SIBDEC_DISP_NONE;
      end
    endcase
    // Frame base with no displacement mode means the base is a long displacement instead.
    if (base_f == sibdec_pkg::SIBDEC_BASE_FRAME && mod_f == sibdec_pkg::SIBDEC_MOD_NODISP) begin
      base_term         = req.disp;                       // RQ7
      res_next.disp_len = sibdec_pkg::SIBDEC_DISP_LONG;   // RQ7
    end
    // The address table outside this byte form is not decoded here, so it reads as zero.
    if (res_next.sib_present) begin
      res_next.effective_address = base_term + index_term + disp_term; // RQ9
    end else begin
      res_next.disp_len = sibdec_pkg::SIBDEC_DISP_NONE;
    end
    // Stack pointer base, or frame base with a displacement, defaults to the stack segment. With a
    // scale-index-base byte every other base is on the data segment, whatever the 16-bit hint says.
    if (res_next.sib_present) begin
      if (base_f == sibdec_pkg::SIBDEC_BASE_STACK
          || (base_f == sibdec_pkg::SIBDEC_BASE_FRAME && (mod_f == sibdec_pkg::SIBDEC_MOD_BYTE
          || mod_f == sibdec_pkg::SIBDEC_MOD_LONG))) begin
        res_next.default_seg = sibdec_pkg::SIBDEC_SEG_STACK; // RQ10
      end else begin
        res_next.default_seg = sibdec_pkg::SIBDEC_SEG_DATA;  // RQ10
      end
    end else if (req.frame16_based) begin
      res_next.default_seg = sibdec_pkg::SIBDEC_SEG_STACK; // RQ17
    end else begin
      res_next.default_seg = sibdec_pkg::SIBDEC_SEG_DATA;  // RQ10
    end
    // String destinations ignore any override; other operands honour it.
    if (req.string_dst) begin
      res_next.operand_seg = sibdec_pkg::SIBDEC_SEG_EXTRA; // RQ18
    end else if (req.override_valid) begin
      res_next.operand_seg = req.override_seg;
    end else begin
      res_next.operand_seg = res_next.default_seg;
    end
    // Segment selectors share one decode.
    res_next.seg2_reg      = seg_decode({1'b0, req.seg2}); // RQ12
    res_next.seg3_reg      = seg_decode(req.seg3);         // RQ13
    res_next.seg3_reserved = res_next.seg3_reg == sibdec_pkg::SIBDEC_SEG_NONE; // RQ20
    // Register selector source; the r/m field names a register only in register mode.
    unique case (req.reg_src)
      sibdec_pkg::SIBDEC_SRC_REGFIELD: begin
        sel                = regf_f;                           // RQ14
        res_next.gpr_valid = 1'b1;
      end
      sibdec_pkg::SIBDEC_SRC_RMFIELD: begin
        sel                = rm_f;                             // RQ14
        res_next.gpr_valid = mod_f == sibdec_pkg::SIBDEC_MOD_REG; // RQ14
      end
      default: begin
        sel                = req.opcode_reg;                   // RQ14
        res_next.gpr_valid = 1'b1;
      end
    endcase
    // Byte operands reach only the first four registers, low or second byte.
    if (req.w_present && !req.w) begin
      res_next.gpr_num  = {1'b0, sel[1:0]};                    // RQ16
      res_next.gpr_part = sel[2] ? sibdec_pkg::SIBDEC_PART_HIGH
                                 : sibdec_pkg::SIBDEC_PART_LOW; // RQ11 RQ16
    end else begin
      res_next.gpr_num  = sel;                                 // RQ15
      res_next.gpr_part = sibdec_pkg::SIBDEC_PART_FULL;        // RQ11 RQ15
    end
    res_next.gpr_width16 = !req.opsize32;                      // RQ11 RQ15
    // Direction one makes the register the destination.
    res_next.reg_is_dst  = req.d;                              // RQ19
    // Without a request the last result stands, so the datapath may sample it at leisure.
    if (!req_valid) begin
      res_next = res_reg;
    end
  end

  // ****************************************
  // Result register
  // ****************************************

  // Plain result register; whether a result is held is decided in the decode above.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg   <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      res_reg   <= res_next;
    end
  end

  assign res       = res_reg;
  assign res_valid = valid_reg;
  // The exception logic only sees a reserved code for a request that was actually decoded.
  assign seg_fault = valid_reg && res_reg.seg3_reserved; // RQ20

  // ****************************************
  // Checks
  // ****************************************

  sib_detect_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
    req_valid |=> res.sib_present == ($past(req.addr32) && $past(req.modrm[2:0]) == 3'h4
                                      && $past(req.modrm[7:6]) != 2'h3))
    else $error("Scale-index-base detection wrong.");

  scaled_index_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
    req_valid && req.addr32 && req.modrm == 8'h04 && req.sib[2:0] == 3'h0 && req.sib[5:3] != 3'h4
    |=> res.effective_address == 32'($past(gpr_values[req.sib[2:0]]) +
        ($past(gpr_values[req.sib[5:3]]) << $past(req.sib[7:6]))))
    else $error("Scaled index sum wrong.");

  no_index_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
    req_valid && req.addr32 && req.modrm[7:6] == 2'h0 && req.modrm[2:0] == 3'h4
    && req.sib[5:3] == 3'h4 && req.sib[2:0] != 3'h5
    |=> res.effective_address == $past(gpr_values[req.sib[2:0]]))
    else $error("Index code 100 still added an index.");

  long_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
    req_valid && req.addr32 && req.modrm[7:6] == 2'h0 && req.modrm[2:0] == 3'h4
    && req.sib[2:0] == 3'h5 && req.sib[5:3] == 3'h4
    |=> res.effective_address == $past(req.disp) && res.disp_len == 3'h4)
    else $error("Long displacement base not used.");

  byte_disp_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
    req_valid && req.addr32 && req.modrm[7:6] == 2'h1 && req.modrm[2:0] == 3'h4
    |=> res.disp_len == 3'h1)
    else $error("Byte displacement length wrong.");

  stack_default_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
    req_valid && req.addr32 && req.modrm[2:0] == 3'h4 && req.modrm[7:6] != 2'h3 && req.sib[2:0] == 3'h4
    |=> res.default_seg == sibdec_pkg::SIBDEC_SEG_STACK)
    else $error("Stack pointer base not on stack segment.");

  string_extra_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ18
    req_valid && req.string_dst |=> res.operand_seg == sibdec_pkg::SIBDEC_SEG_EXTRA)
    else $error("String destination left extra segment.");

  reserved_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ20
    req_valid && req.seg3[2:1] == 2'h3 |=> seg_fault && res.seg3_reg == sibdec_pkg::SIBDEC_SEG_NONE)
    else $error("Reserved segment code not flagged.");

  byte_reg_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ16
    req_valid && req.w_present && !req.w && req.reg_src == sibdec_pkg::SIBDEC_SRC_REGFIELD
    |=> res.gpr_num == {1'b0, $past(req.modrm[4:3])}
        && (res.gpr_part == sibdec_pkg::SIBDEC_PART_HIGH) == $past(req.modrm[5]))
    else $error("Byte register select wrong.");

  direction_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ19
    req_valid |=> res.reg_is_dst == $past(req.d))
    else $error("Direction decode wrong.");

  // Two-bit selector codes name the first four segment registers in order.
  seg_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
    req_valid |=> res.seg2_reg == sibdec_pkg::sibdec_seg_type'({1'b0, $past(req.seg2)}))
    else $error("Two-bit segment decode wrong.");

  // Codes 100 and 101 reach the two added segments and raise no fault.
  seg_added_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
    req_valid && req.seg3[2:1] == 2'h2 |=> !seg_fault && res.seg3_reg == ($past(req.seg3[0])
      ? sibdec_pkg::SIBDEC_SEG_ADD_TWO : sibdec_pkg::SIBDEC_SEG_ADD_ONE))
    else $error("Added segment decode wrong.");

  // The r/m field names a register only in register mode.
  rm_register_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
    req_valid && req.reg_src == sibdec_pkg::SIBDEC_SRC_RMFIELD
    |=> res.gpr_valid == ($past(req.modrm[7:6]) == 2'h3))
    else $error("Register mode select wrong.");

  // Without a byte length the selector passes through as a full register.
  full_reg_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
    req_valid && !(req.w_present && !req.w) && req.reg_src == sibdec_pkg::SIBDEC_SRC_OPCODE
    |=> res.gpr_num == $past(req.opcode_reg) && res.gpr_part == sibdec_pkg::SIBDEC_PART_FULL)
    else $error("Full register select wrong.");

  // A 16-bit frame base operand with no scale-index-base byte is on the stack segment.
  frame16_stack_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
    req_valid && req.frame16_based && !req.addr32
    |=> res.default_seg == sibdec_pkg::SIBDEC_SEG_STACK)
    else $error("Frame base operand off stack segment.");

endmodule : sibdec_decoder

// ### dv/sibdec_regfile_model.sv
// Behavioural general register file that feeds the decoder with fresh contents each cycle.
`timescale 1ns/1ps

module sibdec_regfile_model #(
  parameter int SEED = 32'h7a11_0c05 // Own stream, so register data never mirrors the request data.
) (
  input  wire logic                    sys_clk,
  output logic [7:0][31:0]             gpr_values
);
  int seed_reg; // Random stream state.

  // ****************************************
  // Register contents
  // ****************************************
  // Contents change just after every edge, like a busy datapath; near-full values are mixed in
  // on purpose, because address sums that wrap past 32 bits are where adders usually go wrong.
  initial begin
    seed_reg = SEED;
    gpr_values = '0;
    forever begin
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 8; i++) begin
        if ($random(seed_reg) % 4 == 0) begin
          gpr_values[i] = 32'hffff_fff0 | i;
        end else begin
          gpr_values[i] = $random(seed_reg);
        end
      end
    end
  end
endmodule : sibdec_regfile_model

// ### dv/sibdec_decoder_tb.sv
// Self-checking bench for the addressing and operand field decoder.
`timescale 1ns/1ps

module sibdec_decoder_tb;
  logic                       sys_clk;     // Bench clock, 25 ns.
  logic                       rst_n;       // Active-low reset.
  logic                       req_valid;   // Request strobe.
  sibdec_pkg::sibdec_req_type req;         // Request fields.
  logic [7:0][31:0]           gpr_values;  // Register file from the model.
  logic                       res_valid;   // Result strobe.
  sibdec_pkg::sibdec_res_type res;         // Result fields.
  logic                       seg_fault;   // Reserved selector flag.
  sibdec_pkg::sibdec_res_type exp_r;       // Expected result of the last taken request.
  sibdec_pkg::sibdec_req_type r;           // Request being built.
  int                         num_errors;  // Mismatches.
  int                         n_compared;  // Comparisons.
  int                         seed;        // Random stream state.

  sibdec_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
                        .gpr_values(gpr_values), .res_valid(res_valid), .res(res), .seg_fault(seg_fault));
  sibdec_regfile_model u_model (.sys_clk(sys_clk), .gpr_values(gpr_values));

  // ****************************************
  // Reference model
  // ****************************************
  // Expected decode of one request, built from the field rules alone.
  function automatic sibdec_pkg::sibdec_res_type expect_res(sibdec_pkg::sibdec_req_type q, logic [7:0][31:0] g);
    sibdec_pkg::sibdec_res_type e;
    logic [1:0] md;
    logic [2:0] ix;
    logic [2:0] bs;
    logic [2:0] sel;
    e = '0;
    md = q.modrm[7:6];
    ix = q.sib[5:3];
    bs = q.sib[2:0];
    e.sib_present = q.addr32 && q.modrm[2:0] == 3'h4 && md != 2'h3;
    e.default_seg = q.frame16_based ? sibdec_pkg::SIBDEC_SEG_STACK : sibdec_pkg::SIBDEC_SEG_DATA;
    if (e.sib_present) begin
      e.effective_address = (ix == 3'h4) ? 32'h0000_0000 : g[ix] << q.sib[7:6];
      e.effective_address += (bs == 3'h5 && md == 2'h0) ? q.disp : g[bs];
      e.disp_len = (bs == 3'h5 && md == 2'h0) ? 3'h4 : (md == 2'h1) ? 3'h1 : (md == 2'h2) ? 3'h4 : 3'h0;
      if (md == 2'h1) begin
        e.effective_address += {{24{q.disp[7]}}, q.disp[7:0]};
      end else if (md == 2'h2) begin
        e.effective_address += q.disp;
      end
      e.default_seg = (bs == 3'h4 || (bs == 3'h5 && md != 2'h0)) ? sibdec_pkg::SIBDEC_SEG_STACK
                                                                  : sibdec_pkg::SIBDEC_SEG_DATA;
    end
    e.operand_seg = q.string_dst ? sibdec_pkg::SIBDEC_SEG_EXTRA : q.override_valid ? q.override_seg : e.default_seg;
    e.seg2_reg = sibdec_pkg::sibdec_seg_type'({1'b0, q.seg2});
    e.seg3_reserved = q.seg3[2:1] == 2'h3;
    e.seg3_reg = e.seg3_reserved ? sibdec_pkg::SIBDEC_SEG_NONE : sibdec_pkg::sibdec_seg_type'(q.seg3);
    sel = (q.reg_src == sibdec_pkg::SIBDEC_SRC_OPCODE) ? q.opcode_reg
        : (q.reg_src == sibdec_pkg::SIBDEC_SRC_REGFIELD) ? q.modrm[5:3] : q.modrm[2:0];
    e.gpr_valid = !(q.reg_src == sibdec_pkg::SIBDEC_SRC_RMFIELD && md != 2'h3);
    e.gpr_num = (q.w_present && !q.w) ? {1'b0, sel[1:0]} : sel;
    e.gpr_part = !(q.w_present && !q.w) ? sibdec_pkg::SIBDEC_PART_FULL
               : sel[2] ? sibdec_pkg::SIBDEC_PART_HIGH : sibdec_pkg::SIBDEC_PART_LOW;
    e.gpr_width16 = !q.opsize32;
    e.reg_is_dst = q.d;
    return e;
  endfunction : expect_res

  // ****************************************
  // Bench tasks
  // ****************************************
  // Counts one comparison and reports it at once when it fails.
  task automatic chk(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // Random request that stays within what the producer may encode.
  task automatic rand_req(output sibdec_pkg::sibdec_req_type q);
    logic [95:0] raw;
    raw = {$random(seed), $random(seed), $random(seed)};
    q = raw[$bits(q)-1:0];
    if (raw[95]) q.modrm[2:0] = 3'h4;
    if (q.sib[5:3] == 3'h4) q.sib[7:6] = 2'h0;
    if (q.reg_src == 2'h3) q.reg_src = sibdec_pkg::SIBDEC_SRC_REGFIELD;
    if (q.override_seg > 3'h5) q.override_seg = sibdec_pkg::SIBDEC_SEG_ADD_TWO;
    if (q.addr32) q.frame16_based = 1'b0;
  endtask : rand_req

  // One cycle: takes the inputs seen at the edge, checks the result just after it, then drives anew.
  task automatic step(input bit v, input sibdec_pkg::sibdec_req_type q);
    bit pend;
    @(posedge sys_clk);
    pend = req_valid;
    if (pend) exp_r = expect_res(req, gpr_values);
    #1;
    chk(res_valid === pend, "result strobe");
    chk(seg_fault === (pend && exp_r.seg3_reserved), "fault flag");
    if (pend) begin
      chk({res.effective_address, res.sib_present, res.disp_len} === {exp_r.effective_address, exp_r.sib_present, exp_r.disp_len}, "address");
      chk({res.default_seg, res.operand_seg} === {exp_r.default_seg, exp_r.operand_seg}, "segment choice");
      chk({res.seg2_reg, res.seg3_reg, res.seg3_reserved} === {exp_r.seg2_reg, exp_r.seg3_reg, exp_r.seg3_reserved}, "selectors");
      chk(res.gpr_valid === exp_r.gpr_valid, "register named");
      if (exp_r.gpr_valid) chk({res.gpr_num, res.gpr_part} === {exp_r.gpr_num, exp_r.gpr_part}, "register");
      chk({res.gpr_width16, res.reg_is_dst} === {exp_r.gpr_width16, exp_r.reg_is_dst}, "size direction");
    end else begin
      chk(res === exp_r, "result held");
    end
    req_valid = v;
    req = q;
  endtask : step

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // The run needs about 3,200 cycles; ten thousand leaves ample margin.
  initial begin
    #250_000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    seed = 32'h73aa_a007;
    num_errors = 0;
    n_compared = 0;
    exp_r = '0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // Every mode with every scale-index-base byte whose scale is 00 under index 100, back to back.
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 256; s++) begin
        rand_req(r);
        r.addr32 = 1'b1;
        r.modrm = {m[1:0], r.modrm[5:3], 3'h4};
        r.sib = s[7:0];
        if (r.sib[5:3] == 3'h4) r.sib[7:6] = 2'h0;
        step(1'b1, r);
      end
    end
    // Random traffic with gaps between requests.
    repeat (2000) begin
      rand_req(r);
      step($random(seed) % 4 != 0, r);
    end
    // A reset in mid-run clears the result and the flag; the last request is checked first.
    step(1'b0, r);
    rst_n = 1'b0;
    #1;
    chk(res_valid === 1'b0 && res === '0 && seg_fault === 1'b0, "reset values");
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    exp_r = '0;
    repeat (100) begin
      rand_req(r);
      step(1'b1, r);
    end
    step(1'b0, r);
    step(1'b0, r);
    summarize();
  end
endmodule : sibdec_decoder_tb
